// ==== tam_match.sv ====
// ten-bit multi-address target matcher for a two-wire serial bus
// assumes scl/sda arrive from pins asynchronously; sda is open drain,
// the pad pulls low when sda_oe_n is low; own addresses are quasi-static
`timescale 1ns/100ps
module tam_match
    import tam_pkg::*;
#(
    parameter int NUM_SLOTS = TAM_MAX_SLOTS
) (
    input  wire logic                                   ref_clk,
    input  wire logic                                   rst,
    input  wire logic                                   scl_in,
    input  wire logic                                   sda_in,
    input  wire logic [NUM_SLOTS-1:0]                   slot_en,
    input  wire logic [NUM_SLOTS-1:0][TAM_ADDR_BITS-1:0] own_addr,
    output logic                                        sda_out,
    output logic                                        sda_oe_n,
    output logic      [TAM_BYTE_BITS-1:0]               rx_data,
    output logic                                        rx_valid,
    output logic                                        addr_match,
    output logic      [TAM_SLOT_BITS-1:0]               match_slot,
    output logic                                        addressed
);

    // elaboration check: the slot index port is only two bits wide
    if (NUM_SLOTS < 1 || NUM_SLOTS > TAM_MAX_SLOTS) begin : g_slots_chk
        $error("tam_match: NUM_SLOTS must be 1..4");
    end

    ////////////////////////////////////////////////////////////////////////
    // state word

    typedef struct packed {
        tam_phase_type              phase;      // sequencer phase
        logic                       scl_prev;   // edge detect history
        logic                       sda_prev;   // edge detect history
        logic [3:0]                 bit_cnt;    // bits of current byte
        logic [TAM_BYTE_BITS-1:0]   shift;      // incoming bits
        logic                       ack_pend;   // ack owed at next scl fall
        logic                       ack_on;     // driving the ack bit
        logic [1:0]                 hi;         // upper address bits seen
        logic [TAM_BYTE_BITS-1:0]   lo;         // lower address bits matched
        logic                       sda_oe_n;   // pin drive, low drives
        logic                       sda_out;    // pin level while driven
        logic [TAM_BYTE_BITS-1:0]   rx_data;    // last data byte
        logic                       rx_valid;   // one-cycle byte strobe
        logic                       matched;    // one-cycle match strobe
        logic [TAM_SLOT_BITS-1:0]   slot;       // matching slot index
        logic                       addressed;  // selected until stop/start
    } tam_st_type;

    tam_st_type st_ff;      // registered state
    tam_st_type nxt_st;     // next state

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and bus conditions

    logic [1:0] pins_s;     // synchronised {scl, sda}
    logic       scl_s;      // synchronised clock line
    logic       sda_s;      // synchronised data line

    tam_sync #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({scl_in, sda_in}),
        .q       (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    logic scl_rise;         // clock line rose
    logic scl_fall;         // clock line fell
    logic start_cond;       // sda falls with scl high
    logic stop_cond;        // sda rises with scl high

    assign scl_rise   = scl_s & ~st_ff.scl_prev;
    assign scl_fall   = ~scl_s & st_ff.scl_prev;
    assign start_cond = scl_s & st_ff.scl_prev & st_ff.sda_prev & ~sda_s;
    assign stop_cond  = scl_s & st_ff.scl_prev & ~st_ff.sda_prev & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // address comparison against every slot

    logic [TAM_BYTE_BITS-1:0]   rx_byte;    // byte completed this cycle
    logic                       byte_done;  // eighth bit sampled now
    logic                       prefix_ok;  // first byte carries 11110
    logic                       hi_any;     // some slot shares upper bits
    logic                       full_any;   // some slot matches all ten bits
    logic [TAM_SLOT_BITS-1:0]   full_slot;  // lowest fully matching slot

    assign rx_byte   = {st_ff.shift[TAM_BYTE_BITS-2:0], sda_s};
    assign byte_done = scl_rise && (st_ff.bit_cnt == TAM_CNT_LAST)
                       && (st_ff.phase != TAM_IDLE) && (st_ff.phase != TAM_IGNORE);
    assign prefix_ok = (rx_byte[TAM_BYTE_BITS-1:TAM_PREFIX_POS] == TAM_PREFIX);

    // each slot compared whole; upper and lower halves never mix across slots
    always_comb begin
        hi_any    = 1'b0;
        full_any  = 1'b0;
        full_slot = '0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (slot_en[i] && own_addr[i][9:8] == rx_byte[TAM_HI_POS+1:TAM_HI_POS]) begin
                hi_any = 1'b1;
            end
            if (slot_en[i] && own_addr[i] == {st_ff.hi, rx_byte}) begin
                full_any  = 1'b1;
                full_slot = TAM_SLOT_BITS'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    // stop and start override everything; bits shift on scl rise,
    // ack drive changes only on scl fall so sda is stable while scl high
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.scl_prev = scl_s;
        nxt_st.sda_prev = sda_s;
        nxt_st.rx_valid = 1'b0;
        nxt_st.matched  = 1'b0;
        if (stop_cond) begin
            // bus free: back to idle, release sda, clear bit count, ack state and addressed
            nxt_st.phase     = TAM_IDLE;
            nxt_st.bit_cnt   = '0;
            nxt_st.ack_pend  = 1'b0;
            nxt_st.ack_on    = 1'b0;
            nxt_st.sda_oe_n  = TAM_OE_N_RST;
            nxt_st.addressed = 1'b0;
        end else if (start_cond) begin
            // start or repeated start ends any ignore period
            nxt_st.phase     = TAM_ADR_HI;
            nxt_st.bit_cnt   = '0;
            nxt_st.ack_pend  = 1'b0;
            nxt_st.ack_on    = 1'b0;
            nxt_st.sda_oe_n  = TAM_OE_N_RST;
            nxt_st.addressed = 1'b0;
        end else if (byte_done) begin
            nxt_st.shift   = rx_byte;
            nxt_st.bit_cnt = TAM_CNT_FULL;
            unique case (st_ff.phase)
                TAM_ADR_HI: begin
                    // reads are left to the transfer engine: only writes ack here
                    if (prefix_ok && !rx_byte[TAM_RW_POS] && hi_any) begin
                        nxt_st.ack_pend = 1'b1;
                        nxt_st.hi       = rx_byte[TAM_HI_POS+1:TAM_HI_POS];
                        nxt_st.phase    = TAM_ADR_LO;
                    end else begin
                        nxt_st.phase    = TAM_IGNORE;
                    end
                end
                TAM_ADR_LO: begin
                    if (full_any) begin
                        nxt_st.ack_pend  = 1'b1;
                        nxt_st.lo        = rx_byte;
                        nxt_st.slot      = full_slot;
                        nxt_st.matched   = 1'b1;
                        nxt_st.addressed = 1'b1;
                        nxt_st.phase     = TAM_DATA;
                    end else begin
                        nxt_st.phase     = TAM_IGNORE;
                    end
                end
                TAM_DATA: begin
                    // only reachable after a full match
                    nxt_st.rx_data  = rx_byte;
                    nxt_st.rx_valid = 1'b1;
                    nxt_st.ack_pend = 1'b1;
                end
                default: begin
                    nxt_st.phase = TAM_IGNORE;
                end
            endcase
        end else if (scl_rise && st_ff.bit_cnt < TAM_CNT_LAST
                     && st_ff.phase != TAM_IDLE && st_ff.phase != TAM_IGNORE) begin
            // ordinary data bit
            nxt_st.shift   = rx_byte;
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
        end else if (scl_fall && st_ff.bit_cnt == TAM_CNT_FULL) begin
            if (st_ff.ack_on) begin
                // ack bit over: release and start next byte
                nxt_st.ack_on   = 1'b0;
                nxt_st.sda_oe_n = TAM_OE_N_RST;
                nxt_st.bit_cnt  = '0;
            end else if (st_ff.ack_pend) begin
                nxt_st.ack_pend = 1'b0;
                nxt_st.ack_on   = 1'b1;
                nxt_st.sda_oe_n = 1'b0;
            end else begin
                nxt_st.bit_cnt  = '0;
            end
        end
    end

    // register; released pin and idle bus after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff          <= '0;
            st_ff.scl_prev <= TAM_BUS_IDLE;
            st_ff.sda_prev <= TAM_BUS_IDLE;
            st_ff.sda_oe_n <= TAM_OE_N_RST;
            st_ff.sda_out  <= TAM_SDA_OUT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sda_out    = st_ff.sda_out;
    assign sda_oe_n   = st_ff.sda_oe_n;
    assign rx_data    = st_ff.rx_data;
    assign rx_valid   = st_ff.rx_valid;
    assign addr_match = st_ff.matched;
    assign match_slot = st_ff.slot;
    assign addressed  = st_ff.addressed;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence hi_byte_s;
        st_ff.phase == TAM_ADR_HI && byte_done;
    endsequence

    sequence lo_byte_s;
        st_ff.phase == TAM_ADR_LO && byte_done;
    endsequence

    hi_ack_a: assert property (hi_byte_s ##0 (prefix_ok && !rx_byte[0] && hi_any) |=>
        st_ff.phase == TAM_ADR_LO && st_ff.ack_pend)
        else $error("first byte with matching high bits not accepted");

    prefix_bad_a: assert property (hi_byte_s ##0 !prefix_ok |=> st_ff.phase == TAM_IGNORE)
        else $error("first byte without prefix not ignored");

    full_match_a: assert property (addr_match |-> slot_en[match_slot] &&
        own_addr[match_slot] == {st_ff.hi, st_ff.lo})
        else $error("match reported for slot not fully equal");

    mixed_nack_a: assert property (lo_byte_s ##0 !full_any |=>
        st_ff.phase == TAM_IGNORE && !st_ff.ack_pend ##1 st_ff.sda_oe_n)
        else $error("second byte acked without full match");

    rx_gate_a: assert property (rx_valid |-> addressed && st_ff.phase == TAM_DATA)
        else $error("data captured while not addressed");

    ignore_hold_a: assert property (st_ff.phase == TAM_IGNORE && !start_cond && !stop_cond |=>
        st_ff.phase == TAM_IGNORE && st_ff.sda_oe_n && !rx_valid)
        else $error("ignore period left without start or stop");

    start_rearm_a: assert property (start_cond && !stop_cond |=>
        st_ff.phase == TAM_ADR_HI && st_ff.sda_oe_n && st_ff.bit_cnt == 4'h0)
        else $error("start did not rearm address phase");

    ack_edge_a: assert property ($fell(sda_oe_n) |-> $past(scl_fall) && st_ff.ack_on)
        else $error("ack drive began off a clock fall");

    slot_scope_a: assert property (lo_byte_s ##0 full_any |=> addr_match &&
        int'(match_slot) < NUM_SLOTS && match_slot == $past(full_slot) ##1 !addr_match)
        else $error("match strobe malformed");

endmodule : tam_match

// ==== tam_pkg.sv ====
// shared constants and types for the ten-bit multi-address target matcher
// assumes a single 100 MHz clock domain; no software-visible registers
package tam_pkg;

    // address phase layout
    localparam int          TAM_ADDR_BITS   = 10;       // own address width
    localparam int          TAM_BYTE_BITS   = 8;        // bits per bus byte
    localparam int          TAM_MAX_SLOTS   = 4;        // own-address slots
    localparam int          TAM_SLOT_BITS   = 2;        // slot index width
    localparam logic [4:0]  TAM_PREFIX      = 5'h1e;    // first byte upper bits 11110
    localparam int          TAM_PREFIX_POS  = 3;        // prefix sits in bits 7..3
    localparam int          TAM_HI_POS      = 1;        // upper address bits in 2..1
    localparam int          TAM_RW_POS      = 0;        // direction bit position
    localparam logic [3:0]  TAM_CNT_FULL    = 4'h8;     // bit count at byte end
    localparam logic [3:0]  TAM_CNT_LAST    = 4'h7;     // count before last bit

    // reset levels of the idle bus
    localparam logic        TAM_BUS_IDLE    = 1'b1;     // scl/sda idle high
    localparam logic        TAM_OE_N_RST    = 1'b1;     // pin released in reset
    localparam logic        TAM_SDA_OUT_RST = 1'b0;     // open drain only pulls low

    // sequencer phases, gray along idle->hi->lo->data
    typedef enum logic [2:0] {
        TAM_IDLE   = 3'h0,
        TAM_ADR_HI = 3'h1,
        TAM_ADR_LO = 3'h3,
        TAM_DATA   = 3'h2,
        TAM_IGNORE = 3'h6
    } tam_phase_type;

endpackage : tam_pkg

// ==== tam_sync.sv ====
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to ref_clk; reset value is the idle bus level
`timescale 1ns/100ps
module tam_sync
    import tam_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // elaboration check: at least one line to synchronise
    if (WIDTH < 1) begin : g_width_chk
        $error("tam_sync: WIDTH must be at least 1");
    end

    // both stages as one state word
    typedef struct packed {
        logic [WIDTH-1:0] s1;   // first stage, read only by s2
        logic [WIDTH-1:0] s2;   // second stage, safe to use
    } tam_sync_st_type;

    tam_sync_st_type st_ff;     // registered state
    tam_sync_st_type nxt_st;    // next state

    // shift through two flops
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    // register; reset to idle-high bus
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff <= {(2*WIDTH){TAM_BUS_IDLE}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;

endmodule : tam_sync

// ==== tam_ctrl_model.sv ====
// bus controller model: start, stop and bytes on a pulled-up two-wire bus
// assumes the target pulls sda low through sda_oe_n and drives sda_out low
`timescale 1ns/100ps
module tam_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic sda_oe_n,
    input  wire logic sda_out,
    output logic      scl_in,
    output logic      sda_in
);
    logic scl_lvl  = 1'b1; // controller clock level, idle high
    logic pull_low = 1'b0; // controller pulls data low

    ////////////////////////////////////////////////////////////////////////
    // wired-and with pull-up: a released line reads high, never stale
    assign scl_in = scl_lvl;
    assign sda_in = (pull_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // wait n cycles, then step off the edge
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : w

    // start or repeated start: data falls while clock high
    task automatic start_cond();
        w(3);
        pull_low = 1'b0;
        w(6);
        scl_lvl = 1'b1;
        w(6);
        pull_low = 1'b1;
        w(6);
        scl_lvl = 1'b0;
    endtask : start_cond

    // stop: data rises while clock high
    task automatic stop_cond();
        w(3);
        pull_low = 1'b1;
        w(3);
        scl_lvl = 1'b1;
        w(6);
        pull_low = 1'b0;
        w(6);
    endtask : stop_cond

    // one byte msb first, then the ninth clock; data moves mid-low only
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin // msb first
            w(3);
            pull_low = !b[i];
            w(3);
            scl_lvl = 1'b1;
            w(6);
            scl_lvl = 1'b0;
        end
        w(3);
        pull_low = 1'b0;
        w(3);
        scl_lvl = 1'b1;
        w(6);
        ack = !sda_in; // sampled late in the high phase
        scl_lvl = 1'b0;
    endtask : send_byte
endmodule : tam_ctrl_model

// ==== test_tam_match.sv ====
// testbench for the ten-bit multi-address matcher
// assumes tam_ctrl_model plays the bus controller; all slots driven here
`timescale 1ns/100ps
module test_tam_match
    import tam_pkg::*;
();
    logic                          ref_clk  = 1'b0;
    logic                          rst      = 1'b1;
    logic [3:0]                    slot_en  = 4'hf;
    logic [3:0][TAM_ADDR_BITS-1:0] own_addr = '0;
    logic                          scl_in, sda_in, sda_out, sda_oe_n;
    logic                          rx_valid, addr_match, addressed;
    logic [7:0]                    rx_data, last_rx;
    logic [1:0]                    match_slot;
    logic [1:0]                    ups [4] = '{2'h0, 2'h1, 2'h2, 2'h2}; // upper bits per slot
    logic [9:0]                    a;
    logic                          ack_nb;  // ack seen in hand-made frames
    int                            fails = 0, checked = 0, am_cnt = 0, rv_cnt = 0;

    always #5 ref_clk = ~ref_clk;

    tam_match #(.NUM_SLOTS(4)) tam_match_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in),
        .sda_in(sda_in), .slot_en(slot_en), .own_addr(own_addr), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .rx_data(rx_data), .rx_valid(rx_valid), .addr_match(addr_match),
        .match_slot(match_slot), .addressed(addressed));
    tam_ctrl_model tam_ctrl_model_i (.ref_clk(ref_clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
        .scl_in(scl_in), .sda_in(sda_in));

    ////////////////////////////////////////////////////////////////////////
    // pulse counters; one-cycle outputs are seen at every edge
    always @(posedge ref_clk) begin
        if (addr_match === 1'b1) am_cnt++;
        if (rx_valid === 1'b1) begin
            rv_cnt++;
            last_rx = rx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compares and expectations
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_byte

    // lowest enabled slot equal in all ten bits, -1 if none
    function automatic int exp_slot(input logic [9:0] x);
        for (int i = 0; i < 4; i++)
            if (slot_en[i] && own_addr[i] == x) return i;
        return -1;
    endfunction : exp_slot

    // any enabled slot with the same two upper bits
    function automatic logic exp_hi(input logic [9:0] x);
        for (int i = 0; i < 4; i++)
            if (slot_en[i] && own_addr[i][9:8] == x[9:8]) return 1'b1;
        return 1'b0;
    endfunction : exp_hi

    // address phase plus one data byte; keep skips the stop (repeated start next)
    task automatic xfer(input logic [9:0] x, input logic rw, input logic [7:0] d, input logic keep);
        int   s;
        int   am0;
        int   rv0;
        logic ack;
        s = rw ? -1 : exp_slot(x);
        am0 = am_cnt;
        rv0 = rv_cnt;
        tam_ctrl_model_i.start_cond();
        tam_ctrl_model_i.send_byte({TAM_PREFIX, x[9:8], rw}, ack);
        cmp_bit(ack, exp_hi(x) && !rw);
        tam_ctrl_model_i.send_byte(x[7:0], ack);
        cmp_bit(ack, s >= 0);
        cmp_bit(am_cnt == am0 + 1, s >= 0);
        if (s >= 0) cmp_byte({6'h00, match_slot}, 8'(s));
        tam_ctrl_model_i.send_byte(d, ack);
        cmp_bit(ack, s >= 0);
        cmp_bit(rv_cnt == rv0 + 1, s >= 0);
        if (s >= 0) cmp_byte(last_rx, d);
        cmp_bit(addressed, s >= 0);
        if (!keep) begin
            tam_ctrl_model_i.stop_cond();
            cmp_bit(addressed, 1'b0);
        end
    endtask : xfer

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, per-slot match, cross-slot, refusals, random
    initial begin
        void'($urandom(32'hd024aec4));
        repeat (8) @(posedge ref_clk);
        #1;
        cmp_bit(sda_oe_n, 1'b1); // reset level
        cmp_bit(sda_out, 1'b0); // reset level
        cmp_bit(addressed, 1'b0); // reset level
        cmp_byte(rx_data, 8'h00); // reset level
        for (int i = 0; i < 4; i++) own_addr[i] = {ups[i], 8'($urandom)};
        rst = 1'b0;
        tam_ctrl_model_i.w(3);
        for (int i = 0; i < 4; i++) xfer(own_addr[i], 1'b0, 8'($urandom), 1'b0);
        xfer({ups[0], own_addr[1][7:0]}, 1'b0, 8'h5a, 1'b1);
        xfer({ups[1], own_addr[0][7:0]}, 1'b0, 8'ha5, 1'b1);
        xfer(own_addr[1], 1'b0, 8'hff, 1'b0);
        xfer({2'h3, 8'($urandom)}, 1'b0, 8'h00, 1'b0);
        xfer(own_addr[0], 1'b1, 8'h3c, 1'b0);
        // first byte with a wrong prefix but matching high bits: never acked
        tam_ctrl_model_i.start_cond();
        tam_ctrl_model_i.send_byte({5'h1f, ups[0], 1'b0}, ack_nb);
        cmp_bit(ack_nb, 1'b0);
        tam_ctrl_model_i.send_byte(own_addr[0][7:0], ack_nb);
        cmp_bit(ack_nb, 1'b0);
        tam_ctrl_model_i.stop_cond();
        cmp_bit(addressed, 1'b0);
        slot_en = 4'he;
        xfer(own_addr[0], 1'b0, 8'h81, 1'b0);
        slot_en = 4'hf;
        own_addr[3] = own_addr[2];
        xfer(own_addr[2], 1'b0, 8'h7e, 1'b0);
        for (int n = 0; n < 24; n++) begin
            a = {2'($urandom), 8'($urandom)};
            if ($urandom % 2) a[7:0] = own_addr[$urandom % 4][7:0];
            xfer(a, 1'b0, 8'($urandom), 1'($urandom));
        end
        // recommended setup: every slot shares the same high bits
        for (int i = 0; i < 4; i++) own_addr[i][9:8] = ups[3];
        for (int i = 0; i < 4; i++) xfer(own_addr[i], 1'b0, 8'($urandom), 1'b0);
        give_verdict();
    end

    // watchdog well past the expected run of some 14000 cycles
    initial begin
        #400_000;
        fails++;
        give_verdict();
    end
endmodule : test_tam_match
